// File: rtl/rtdc_transceiver_ctrl.v
// Operation
// - Four-wire mode: driver and receiver always enabled
// - Reset selects four-wire mode
// - DTR echo: driver on when DTR deasserted
// - DTR controlled: receiver on only when DTR asserted
// - Auto mode: driver on while transmit-ready asserted
// - Auto mode: receiver on while transmit-ready deasserted
// - Mode bytes 0x00 to 0x03 select modes
// - Mode byte lives at offset seven
// - New mode byte takes effect immediately
// - DTR asserted means pin driven low
`timescale 1ns/1ps
`include "rtdc_map.vh"
module rtdc_transceiver_ctrl (
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Register port of the serial controller
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR_EN,
  input wire RD_EN,
  output reg [7:0] RDATA,
  // Controller status pins, asynchronous to MCLK
  input wire DTR_N,
  input wire TX_HOLDING_READY_OUT,
  // Line transceiver enables, active high
  output reg DRIVER_EN,
  output reg RECEIVER_EN,
  // Current mode, for observation
  output reg [1:0] MODE
);
  reg [7:0] mode_reg;
  reg [7:0] mode_next;
  reg drv_next;
  reg rcv_next;
  wire dtr_n_s;
  wire tx_holding_ready_out_s;
  wire dtr_asserted;
  wire [1:0] pin_raw;
  wire [1:0] pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, one per status pin
  assign pin_raw = {TX_HOLDING_READY_OUT, DTR_N};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gen_sync
      rtdc_sync u_sync (
        .clk(MCLK),
        .rst(RST),
        .d_in(pin_raw[gi]),
        .q_out(pin_sync[gi])
      );
    end
  endgenerate

  assign dtr_n_s = pin_sync[0];
  assign tx_holding_ready_out_s = pin_sync[1];

  // Asserted means the pin is low
  assign dtr_asserted = ~dtr_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register
  always @* begin
    mode_next = mode_reg;
    if (WR_EN && (ADDR == `RTDC_MODE_OFFSET)) begin
      mode_next = WDATA;
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      mode_reg <= `RTDC_MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD_EN && (ADDR == `RTDC_MODE_OFFSET)) begin
      RDATA <= mode_reg;
    end else if (RD_EN) begin
      RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable decode from the next mode so a write acts at once
  always @* begin
    drv_next = 1'b1;
    rcv_next = 1'b1;
    case (mode_next)
      `RTDC_MODE_FOUR_WIRE: begin
        drv_next = 1'b1;
        rcv_next = 1'b1;
      end
      `RTDC_MODE_DTR_ECHO: begin
        drv_next = ~dtr_asserted;
        rcv_next = 1'b1;
      end
      `RTDC_MODE_DTR_CTRL: begin
        drv_next = ~dtr_asserted;
        rcv_next = dtr_asserted;
      end
      `RTDC_MODE_TX_HOLDING_READY_OUT_AUTO: begin
        drv_next = tx_holding_ready_out_s;
        rcv_next = ~tx_holding_ready_out_s;
      end
      default: begin
        drv_next = 1'b1;
        rcv_next = 1'b1;
      end
    endcase
  end

  always @(posedge MCLK) begin
    if (RST) begin
      DRIVER_EN <= 1'b1;
      RECEIVER_EN <= 1'b1;
      MODE <= 2'h0;
    end else begin
      DRIVER_EN <= drv_next;
      RECEIVER_EN <= rcv_next;
      MODE <= mode_next[1:0];
    end
  end
endmodule // rtdc_transceiver_ctrl

// File: shared/rtdc_map.vh
`ifndef RTDC_MAP_VH
`define RTDC_MAP_VH
// Register offset from the port base
`define RTDC_MODE_OFFSET 3'h7
// Mode byte codes
`define RTDC_MODE_FOUR_WIRE 8'h00
`define RTDC_MODE_DTR_ECHO 8'h01
`define RTDC_MODE_DTR_CTRL 8'h02
`define RTDC_MODE_TX_HOLDING_READY_OUT_AUTO 8'h03
// Reset value of the mode register
`define RTDC_MODE_RESET 8'h00
`endif

// File: rtl/rtdc_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for one level input
module rtdc_sync (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Level in and out
  input wire d_in,
  output wire q_out
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule // rtdc_sync

// File: verif/rtdc_checker.sv
`timescale 1ns/1ps
module rtdc_checker(input wire MCLK,RST,WR_EN,RD_EN,DTR_N,TX_HOLDING_READY_OUT,DRIVER_EN,
  RECEIVER_EN,input wire [2:0] ADDR,input wire [7:0] WDATA,RDATA,input wire [1:0] MODE);
  wire de=DRIVER_EN,re=RECEIVER_EN;
  // Pin checks wait until the synchronisers hold pin values, not reset values
  reg [2:0] rst_q=3'h7;
  wire warm=rst_q==3'h0;
  always @(posedge MCLK) rst_q<={rst_q[1:0],RST};
  default clocking @(posedge MCLK);endclocking
  default disable iff(RST);
  a_four_on:assert property(MODE==2'h0|->de&&re)else $error("4w");
  a_rst_on:assert property($fell(RST)|->de&&re&&MODE==2'h0)else $error("rst");
  a_echo_rx:assert property(MODE==2'h1|->re)else $error("echo");
  a_dtr_tx:assert property(warm&&(MODE==2'h1||MODE==2'h2)|->de==$past(DTR_N,3))
    else $error("dtr");
  a_ctrl_rx:assert property(MODE==2'h2|->re!=de)else $error("ctl");
  a_auto_tx:assert property(warm&&MODE==2'h3|->de==$past(TX_HOLDING_READY_OUT,3))
    else $error("tx");
  a_auto_rx:assert property(MODE==2'h3|->re!=de)else $error("rx");
  a_mode_wr:assert property(WR_EN&&ADDR==3'h7|=>MODE==$past(WDATA[1:0]))
    else $error("wr");
  a_rd_unmap:assert property(RD_EN&&ADDR!=3'h7|=>RDATA==8'h00)else $error("rd");
  cover property(MODE==2'h1&&!de);
  cover property(MODE==2'h2&&re);
  cover property(MODE==2'h3&&de);
endmodule // rtdc_checker
bind rtdc_transceiver_ctrl rtdc_checker i_chk(.*);

// File: verif/rtdc_line.sv
`timescale 1ns/1ps
module rtdc_line(input wire DRIVER_EN,RECEIVER_EN,tx,output wire rx);
  // Biased pair idles high when undriven or receiver off
  assign rx=RECEIVER_EN?(DRIVER_EN?tx:1'h1):1'h1;
endmodule // rtdc_line

// File: verif/tb_rs485_transceiver_direction_control.sv
`timescale 1ns/1ps
module tb_rs485_transceiver_direction_control;
  reg MCLK=0,RST=1,WR_EN=0,RD_EN=0,DTR_N=1,TX_HOLDING_READY_OUT=0;
  reg [2:0] ADDR=0;
  reg [7:0] WDATA=0;
  reg [23:0] t=24'h76bcf6;
  wire [7:0] RDATA;
  wire DRIVER_EN,RECEIVER_EN,rx;
  wire [1:0] MODE;
  integer num_errors=0,n_tests=0,m,p;
  rtdc_transceiver_ctrl i_dut(.*);
  rtdc_line i_line(.DRIVER_EN,.RECEIVER_EN,.tx(1'h0),.rx);
  initial forever #12.5 MCLK=~MCLK;
  task cyc(input integer n);repeat(n) @(posedge MCLK);#1;endtask
  task chk(input [7:0] g,e);n_tests++;if(g!==e) begin
    num_errors++;$display("[FAIL] %0t %h %h",$time,g,e);end endtask
  task acc(input w,input [2:0] a,input [7:0] d);ADDR=a;WDATA=d;WR_EN=w;RD_EN=!w;cyc(1);
    WR_EN=0;RD_EN=0;cyc(1);endtask
  task final_report;
    if(num_errors==0&&n_tests>0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    final_report;
  end
  initial begin
    cyc(12);
    RST=0;
    chk({DRIVER_EN,RECEIVER_EN,MODE},8'hc);
    acc(1,3'h3,8'hff);
    chk({DRIVER_EN,RECEIVER_EN,MODE},8'hc);
    acc(0,3'h3,8'h0);
    chk(RDATA,8'h0);
    // Pins disagree so each mode shows which one it follows
    for(m=0;m<4;m++) for(p=0;p<2;p++) begin
      acc(1,3'h7,m[7:0]);
      DTR_N=p[0];
      TX_HOLDING_READY_OUT=!p[0];
      cyc(4);
      chk({DRIVER_EN,RECEIVER_EN,rx},t[(m*2+p)*3+:3]);
      chk(MODE,m[7:0]);
      acc(0,3'h7,8'h0);
      chk(RDATA,m[7:0]);
      acc(0,3'h3,8'h0);
      chk(RDATA,8'h0);
    end
    // Reset in mid-run leaves the auto mode for four-wire
    RST=1;
    cyc(2);
    RST=0;
    chk({DRIVER_EN,RECEIVER_EN,MODE},8'hc);
    acc(0,3'h7,8'h0);
    chk(RDATA,8'h0);
    // Undefined mode byte keeps both enables on and is stored whole
    DTR_N=0;
    TX_HOLDING_READY_OUT=1;
    acc(1,3'h7,8'h84);
    cyc(4);
    chk({DRIVER_EN,RECEIVER_EN,rx},8'h6);
    acc(0,3'h7,8'h0);
    chk(RDATA,8'h84);
    final_report;
  end
endmodule // tb_rs485_transceiver_direction_control
